//--- rtl/sbt_pkg.sv
// constants for the sixteen bit up timer
package sbt_pkg;
  localparam logic [5:0] MODE_ADDR      = 6'h06;
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam int         CLK_SEL_HI     = 7;
  localparam int         CLK_SEL_LO     = 5;
  localparam int         DIV_SEL_HI     = 4;
  localparam int         DIV_SEL_LO     = 3;
  localparam int         TAP_SEL_HI     = 2;
  localparam int         TAP_SEL_LO     = 0;
  localparam int         TAP_BASE       = 8;
  localparam int         IRQ_FLAG_BIT   = 2;
  localparam int         EDGE_SEL_BIT   = 4;
  localparam logic [2:0] SRC_STOP       = 3'h0;
  localparam logic [2:0] SRC_SYS_CLOCK  = 3'h1;
  localparam logic [2:0] SRC_RSV2       = 3'h2;
  localparam logic [2:0] SRC_PORT_A4    = 3'h3;
  localparam logic [2:0] SRC_FAST_RC    = 3'h4;
  localparam logic [2:0] SRC_RSV5       = 3'h5;
  localparam logic [2:0] SRC_SLOW_RC    = 3'h6;
  localparam logic [2:0] SRC_PORT_A0    = 3'h7;
  localparam logic [1:0] DIV_1          = 2'h0;
  localparam logic [1:0] DIV_4          = 2'h1;
  localparam logic [1:0] DIV_16         = 2'h2;
  localparam logic [1:0] DIV_64         = 2'h3;
  localparam logic [5:0] DIV_1_TERM     = 6'h00;
  localparam logic [5:0] DIV_4_TERM     = 6'h03;
  localparam logic [5:0] DIV_16_TERM    = 6'h0f;
  localparam logic [5:0] DIV_64_TERM    = 6'h3f;
  localparam logic [5:0] PRESC_RESET    = 6'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
endpackage

//--- rtl/sbt_prescaler.sv
// divide-by-1/4/16/64 prescaler for the timer clock ticks
`timescale 1ns/1ps
module sbt_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick_in,
  input  wire logic [1:0] div_sel,
  output logic            tick_out
);
  typedef struct packed {
    logic [5:0] cnt;
  } sbt_presc_type;

  sbt_presc_type s_q;
  sbt_presc_type s_d;

  // terminal count for each divisor code
  function automatic logic [5:0] sbt_term(input logic [1:0] sel);
    unique case (sel)
      sbt_pkg::DIV_1:  sbt_term = sbt_pkg::DIV_1_TERM;
      sbt_pkg::DIV_4:  sbt_term = sbt_pkg::DIV_4_TERM;
      sbt_pkg::DIV_16: sbt_term = sbt_pkg::DIV_16_TERM;
      sbt_pkg::DIV_64: sbt_term = sbt_pkg::DIV_64_TERM;
    endcase
  endfunction

  // a tick passes once every divisor input ticks
  assign tick_out = tick_in && (s_q.cnt >= sbt_term(div_sel));

  always_comb begin
    s_d = s_q;
    if (tick_in) begin
      if (tick_out) begin
        s_d.cnt = sbt_pkg::PRESC_RESET;
      end else begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.cnt <= sbt_pkg::PRESC_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

//--- rtl/sbt_timer.sv
// sixteen bit up timer: mode register, clock select, counter, tap edge request
`timescale 1ns/1ps
module sbt_timer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_wr_en,
  input  wire logic        io_rd_en,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        counter_load_instr,
  input  wire logic [15:0] counter_load_data,
  input  wire logic        counter_read_instr,
  output logic      [15:0] counter_read_data,
  input  wire logic        fast_rc_osc,
  input  wire logic        slow_rc_osc,
  input  wire logic        port_a_bit0,
  input  wire logic        port_a_bit4,
  input  wire logic        edge_select_fall,
  input  wire logic        irq_flag_wr,
  input  wire logic        irq_flag_wbit,
  output logic             timer_irq_flag,
  output logic      [15:0] counter_value
);
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] count;
    logic [15:0] rd_copy;
    logic [7:0]  rdata;
    logic        tap;
    logic        flag;
    logic [3:0]  src_prev;
  } sbt_state_type;

  sbt_state_type s_q;
  sbt_state_type s_d;

  logic [2:0] clk_sel;
  logic [1:0] div_sel;
  logic [2:0] tap_sel;
  logic [3:0] src_now;
  logic       src_tick;
  logic       cnt_tick;
  logic       tap_now;
  logic       tap_event;
  logic       flag_clear;

  assign clk_sel = s_q.mode[sbt_pkg::CLK_SEL_HI:sbt_pkg::CLK_SEL_LO];
  assign div_sel = s_q.mode[sbt_pkg::DIV_SEL_HI:sbt_pkg::DIV_SEL_LO];
  assign tap_sel = s_q.mode[sbt_pkg::TAP_SEL_HI:sbt_pkg::TAP_SEL_LO];

  // external clock sources are counted on their rising edges
  assign src_now = {port_a_bit0, slow_rc_osc, fast_rc_osc, port_a_bit4};

  function automatic logic sbt_rise(input logic [3:0] now, input logic [3:0] prev,
                                    input int idx);
    sbt_rise = now[idx] && !prev[idx];
  endfunction

  // source selection; stop and reserved codes give no ticks
  always_comb begin
    unique case (clk_sel)
      sbt_pkg::SRC_SYS_CLOCK: src_tick = 1'b1;
      sbt_pkg::SRC_PORT_A4:   src_tick = sbt_rise(src_now, s_q.src_prev, 0);
      sbt_pkg::SRC_FAST_RC:   src_tick = sbt_rise(src_now, s_q.src_prev, 1);
      sbt_pkg::SRC_SLOW_RC:   src_tick = sbt_rise(src_now, s_q.src_prev, 2);
      sbt_pkg::SRC_PORT_A0:   src_tick = sbt_rise(src_now, s_q.src_prev, 3);
      default:                src_tick = 1'b0;
    endcase
  end

  sbt_prescaler u_presc (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick_in  (src_tick),
    .div_sel  (div_sel),
    .tick_out (cnt_tick)
  );

  // tap taken from the upper byte of the counter
  assign tap_now    = s_q.count[sbt_pkg::TAP_BASE + int'(tap_sel)];
  assign tap_event  = edge_select_fall ? (s_q.tap && !tap_now)
                                       : (!s_q.tap && tap_now);
  assign flag_clear = irq_flag_wr && !irq_flag_wbit;

  always_comb begin
    s_d          = s_q;
    s_d.src_prev = src_now;
    s_d.tap      = tap_now;
    if (io_wr_en && (io_addr == sbt_pkg::MODE_ADDR)) begin
      s_d.mode = io_wdata;
    end
    if (io_rd_en) begin
      s_d.rdata = (io_addr == sbt_pkg::MODE_ADDR) ? s_q.mode : 8'h00;
    end
    // load wins over a tick in the same cycle
    if (counter_load_instr) begin
      s_d.count = counter_load_data;
    end else if (cnt_tick) begin
      s_d.count = s_q.count + 16'h0001;
    end
    if (counter_read_instr) begin
      s_d.rd_copy = s_q.count;
    end
    // set beats a clear in the same cycle; enable plays no part
    if (tap_event) begin
      s_d.flag = 1'b1;
    end else if (flag_clear) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.mode     <= sbt_pkg::MODE_RESET;
      s_q.count    <= sbt_pkg::COUNT_RESET;
      s_q.rd_copy  <= sbt_pkg::COUNT_RESET;
      s_q.rdata    <= 8'h00;
      s_q.tap      <= 1'b0;
      s_q.flag     <= 1'b0;
      s_q.src_prev <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign io_rdata          = s_q.rdata;
  assign counter_read_data = s_q.rd_copy;
  assign timer_irq_flag    = s_q.flag;
  assign counter_value     = s_q.count;

  a_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
    io_wr_en && io_addr == sbt_pkg::MODE_ADDR |=> s_q.mode == $past(io_wdata))
    else $error("mode register did not take the written value");

  a_mode_read: assert property (@(posedge clk) disable iff (!rst_n)
    io_rd_en && io_addr == sbt_pkg::MODE_ADDR |=> io_rdata == $past(s_q.mode))
    else $error("mode register read returned a wrong value");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
    io_rd_en && io_addr != sbt_pkg::MODE_ADDR |=> io_rdata == 8'h00)
    else $error("unmapped read did not return zero");

  a_stop_holds: assert property (@(posedge clk) disable iff (!rst_n)
    clk_sel == sbt_pkg::SRC_STOP && !counter_load_instr |=> $stable(s_q.count))
    else $error("counter moved while stopped");

  a_reserved_idle: assert property (@(posedge clk) disable iff (!rst_n)
    clk_sel == sbt_pkg::SRC_RSV2 || clk_sel == sbt_pkg::SRC_RSV5 |-> !cnt_tick)
    else $error("reserved source produced a tick");

  a_sys_every: assert property (@(posedge clk) disable iff (!rst_n)
    clk_sel == sbt_pkg::SRC_SYS_CLOCK && div_sel == sbt_pkg::DIV_1 |-> cnt_tick)
    else $error("system clock at divide by 1 missed a tick");

  a_div_four: assert property (@(posedge clk) disable iff (!rst_n)
    clk_sel == sbt_pkg::SRC_SYS_CLOCK && div_sel == sbt_pkg::DIV_4 && cnt_tick
    ##1 (clk_sel == sbt_pkg::SRC_SYS_CLOCK && div_sel == sbt_pkg::DIV_4)[*4]
    |-> cnt_tick && !$past(cnt_tick) && !$past(cnt_tick, 2) && !$past(cnt_tick, 3))
    else $error("prescaler period wrong at divide by 4");

  a_div_sixty4: assert property (@(posedge clk) disable iff (!rst_n)
    clk_sel == sbt_pkg::SRC_SYS_CLOCK && div_sel == sbt_pkg::DIV_64 && cnt_tick
    ##1 (clk_sel == sbt_pkg::SRC_SYS_CLOCK && div_sel == sbt_pkg::DIV_64)[*8]
    |-> !cnt_tick)
    else $error("prescaler ticked too early at divide by 64");

  a_count_up: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_tick && !counter_load_instr |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("counter did not step up by one");

  a_never_down: assert property (@(posedge clk) disable iff (!rst_n)
    !counter_load_instr
    |=> s_q.count == $past(s_q.count) || s_q.count == $past(s_q.count) + 16'h0001)
    else $error("counter moved other than one step up");

  a_count_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_tick && !counter_load_instr && s_q.count == 16'hffff |=> s_q.count == 16'h0000)
    else $error("counter did not wrap to zero");

  a_load_value: assert property (@(posedge clk) disable iff (!rst_n)
    counter_load_instr |=> s_q.count == $past(counter_load_data))
    else $error("load did not set the counter");

  a_read_copy: assert property (@(posedge clk) disable iff (!rst_n)
    counter_read_instr |=> counter_read_data == $past(s_q.count))
    else $error("read did not copy the counter");

  a_read_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !counter_read_instr |=> $stable(counter_read_data))
    else $error("read copy changed without a read");

  a_tap_event: assert property (@(posedge clk) disable iff (!rst_n)
    !edge_select_fall && !s_q.tap && s_q.count[sbt_pkg::TAP_BASE + int'(tap_sel)]
    |=> timer_irq_flag)
    else $error("rising tap edge did not set the flag");

  a_fall_event: assert property (@(posedge clk) disable iff (!rst_n)
    edge_select_fall && s_q.tap && !s_q.count[sbt_pkg::TAP_BASE + int'(tap_sel)]
    |=> timer_irq_flag)
    else $error("falling tap edge did not set the flag");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    timer_irq_flag && !flag_clear |=> timer_irq_flag)
    else $error("timer flag dropped without a clear");

  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    flag_clear && !tap_event |=> !timer_irq_flag)
    else $error("timer flag not cleared by a zero write");

  a_flag_nospont: assert property (@(posedge clk) disable iff (!rst_n)
    !timer_irq_flag && !tap_event |=> !timer_irq_flag)
    else $error("timer flag set with no event");
endmodule

//--- tb/sbt_cpu_model.sv
// cpu side model: i/o register accesses, counter load and read, flag writes
`timescale 1ns/1ps
module sbt_cpu_model (
  input  wire logic        clk,
  output logic      [5:0]  io_addr,
  output logic             io_wr_en,
  output logic             io_rd_en,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  output logic             counter_load_instr,
  output logic      [15:0] counter_load_data,
  output logic             counter_read_instr,
  input  wire logic [15:0] counter_read_data,
  output logic             irq_flag_wr,
  output logic             irq_flag_wbit
);
  initial begin
    {io_addr, io_wr_en, io_rd_en, io_wdata} = 16'h0000;
    {counter_load_instr, counter_load_data, counter_read_instr} = 18'h00000;
    {irq_flag_wr, irq_flag_wbit} = 2'h0;
  end
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr_en = 1'h1;
    @(negedge clk);
    io_wr_en = 1'h0;
  endtask
  task rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd_en = 1'h1;
    @(negedge clk);
    io_rd_en = 1'h0;
    d = io_rdata;
  endtask
  task ld(input logic [15:0] v);
    @(negedge clk);
    counter_load_data = v;
    counter_load_instr = 1'h1;
    @(negedge clk);
    counter_load_instr = 1'h0;
  endtask
  task rc(output logic [15:0] v);
    @(negedge clk);
    counter_read_instr = 1'h1;
    @(negedge clk);
    counter_read_instr = 1'h0;
    v = counter_read_data;
  endtask
  task fw(input logic b);
    @(negedge clk);
    irq_flag_wbit = b;
    irq_flag_wr = 1'h1;
    @(negedge clk);
    irq_flag_wr = 1'h0;
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the sixteen bit up timer
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst_n;
  logic        edge_select_fall;
  logic [7:0]  cyc = 8'h00;
  logic [7:0]  b8;
  logic [15:0] a;
  logic [15:0] b;
  int          failures;
  int          samples_checked;
  wire  [5:0]  io_addr;
  wire  [7:0]  io_wdata, io_rdata;
  wire         io_wr_en, io_rd_en, ld_en, rd_en, fl_wr, fl_wbit, timer_irq_flag;
  wire  [15:0] ld_data, rd_data, counter_value;
  logic [15:0] rate [8] = '{16'h0000, 16'h0100, 16'h0000, 16'h0040,
                           16'h0080, 16'h0000, 16'h0020, 16'h0010};
  sbt_timer i_sbt_timer (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr_en(io_wr_en),
    .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .counter_load_instr(ld_en), .counter_load_data(ld_data), .counter_read_instr(rd_en),
    .counter_read_data(rd_data), .fast_rc_osc(cyc[0]), .slow_rc_osc(cyc[2]),
    .port_a_bit0(cyc[3]), .port_a_bit4(cyc[1]), .edge_select_fall(edge_select_fall),
    .irq_flag_wr(fl_wr), .irq_flag_wbit(fl_wbit), .timer_irq_flag(timer_irq_flag),
    .counter_value(counter_value));
  sbt_cpu_model i_sbt_cpu_model (.clk(clk), .io_addr(io_addr), .io_wr_en(io_wr_en),
    .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .counter_load_instr(ld_en), .counter_load_data(ld_data), .counter_read_instr(rd_en),
    .counter_read_data(rd_data), .irq_flag_wr(fl_wr), .irq_flag_wbit(fl_wbit));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // source levels rise every 2, 4, 8 and 16 cycles
  always @(negedge clk) cyc <= cyc + 8'h01;
  task cmp_val(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task cmp_flag(input string n, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // counter advance over a 256 cycle window
  task rate_run(input logic [7:0] m, input logic [15:0] e);
    i_sbt_cpu_model.wr(6'h06, m);
    i_sbt_cpu_model.rc(a);
    repeat (254) @(negedge clk);
    i_sbt_cpu_model.rc(b);
    cmp_val("ticks", e, b - a);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict;
  end
  initial begin
    rst_n = 1'h0;
    edge_select_fall = 1'h0;
    failures = 0;
    samples_checked = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    i_sbt_cpu_model.rd(6'h06, b8);
    cmp_val("mode", 16'h0000, {8'h00, b8});
    cmp_val("count", 16'h0000, counter_value);
    cmp_flag("flag", 1'h0, timer_irq_flag);
    i_sbt_cpu_model.wr(6'h06, 8'hb5);
    i_sbt_cpu_model.rd(6'h06, b8);
    cmp_val("mode", 16'h00b5, {8'h00, b8});
    i_sbt_cpu_model.rd(6'h07, b8);
    cmp_val("unmapped", 16'h0000, {8'h00, b8});
    $display("test registers done");
    for (int i = 0; i < 8; i++) rate_run({i[2:0], 5'h00}, rate[i]);
    for (int i = 0; i < 4; i++) rate_run({3'h1, i[1:0], 3'h0}, 16'h0100 >> (2 * i));
    $display("test sources done");
    i_sbt_cpu_model.wr(6'h06, 8'h00);
    i_sbt_cpu_model.ld(16'hbeef);
    i_sbt_cpu_model.rc(a);
    cmp_val("load", 16'hbeef, a);
    i_sbt_cpu_model.ld(16'hfff0);
    rate_run(8'h20, 16'h0100);
    $display("test load done");
    for (int n = 0; n < 8; n++) for (int e = 0; e < 2; e++) begin
      edge_select_fall = e[0];
      i_sbt_cpu_model.wr(6'h06, {5'h00, n[2:0]});
      i_sbt_cpu_model.ld((16'h0001 << (8 + n + e)) - 16'h0003);
      @(negedge clk);
      i_sbt_cpu_model.fw(1'h0);
      cmp_flag("idle", 1'h0, timer_irq_flag);
      i_sbt_cpu_model.wr(6'h06, {5'h04, n[2:0]});
      repeat (8) @(negedge clk);
      cmp_flag("tap", 1'h1, timer_irq_flag);
    end
    i_sbt_cpu_model.fw(1'h1);
    cmp_flag("keep", 1'h1, timer_irq_flag);
    i_sbt_cpu_model.fw(1'h0);
    cmp_flag("clear", 1'h0, timer_irq_flag);
    $display("test taps done");
    give_verdict;
  end
endmodule
